// *** rtl/atc_core.sv ***
// Asynchronous timer core: prescaler, counter, calendar, flags, events, wake.
// Functional notes
// [R1] Calendar mode makes the counter a packed date/time, read and written as such.
// [R2] Seconds, minutes, hours kept as a 24-hour clock, hours wrap after 23.
// [R3] Day of month and month both count from one.
// [R4] Year is a six-bit offset from a software-chosen leap year.
// [R5] Every year offset divisible by four gets February 29, no other exceptions.
// [R6] Calendar mode keeps alarm and periodic events but no wrap overflow; software writes alarms as dates.
// [R7] Five interrupt outputs: overflow, periodic, alarm, clock settled, ready.
// [R8] Overflow raised on counter wrap and on alarm match with clear-on-match.
// [R9] Settled flag on clock-switching fall, ready flag on busy fall.
// [R10] Ones in mask-set set mask bits, ones in mask-clear clear them.
// [R11] Interrupt asserted while flag and mask set, until status clear write.
// [R12] Periodic flag on rising edge of prescaler bit chosen per channel.
// [R13] Alarm flag when enabled counter reaches the alarm compare value.
// [R14] Software keeps new interval and alarm values ahead of their events.
// [R15] Clear-on-match alarm resets the counter and sets the overflow flag.
// [R16] Overflow, periodic and alarm events pulse, gated by set/clear event mask.
// [R17] Wake request on enabled sources regardless of interrupt masks.
// [R18] Wake stays asserted until cleared through the status clear word.
// [R19] Shutdown wake clears the interrupt mask only; all else is kept.
// [R20] Tuner slow mode drops one tick per roundup(256/value)*2^exp+1 ticks.
// [R21] Tuner fast mode adds one tick per roundup(256/value)*2^exp-1 ticks.
// [R22] While busy, synchronised writes are discarded and their reads give zero, except the event mask.
// [R23] Counter mode counts to all ones, wraps to zero, sets overflow.
// [R24] Counter advances on rising edge of the prescaler bit chosen by psel.
// [R25] Calendar tick carries seconds, minutes, hours, days, months, years.
`timescale 1ns/1ns
module atc_core #(
  parameter int unsigned SYNC_CYCLES     = atc_pkg::SYNC_CYCLES,
  parameter int unsigned CLK_SYNC_CYCLES = atc_pkg::CLK_SYNC_CYCLES
) (
  // Clock and reset
  input  wire logic                                       clk_sys,
  input  wire logic                                       reset_n,
  // Prescaler source clock, one pulse per source period
  input  wire logic                                       src_tick,
  // Source clock enable
  input  wire logic                                       clk_en_wr,
  input  wire logic                                       clk_en_wdata,
  // Control word
  input  wire logic                                       ctrl_wr,
  input  wire atc_pkg::atc_ctrl_t                         ctrl_wdata,
  // Counter and calendar values
  input  wire logic                                       cv_wr,
  input  wire logic                                       calendar_value_wr,
  input  wire logic [atc_pkg::CNT_W-1:0]                  cv_wdata,
  // Status clear, mask set and mask clear
  input  wire logic                                       status_clear_wr,
  input  wire logic [atc_pkg::FLAG_W-1:0]                 status_clear_wdata,
  input  wire logic                                       irq_mask_set_wr,
  input  wire logic                                       irq_mask_clear_wr,
  input  wire logic [atc_pkg::FLAG_W-1:0]                 irq_mask_wdata,
  // Wake enable and event mask
  input  wire logic                                       wake_enable_wr,
  input  wire logic [atc_pkg::EVT_W-1:0]                  wake_enable_wdata,
  input  wire logic                                       event_mask_set_wr,
  input  wire logic                                       event_mask_clear_wr,
  input  wire logic [atc_pkg::EVT_W-1:0]                  event_mask_wdata,
  // Alarm compare and periodic interval, channel chosen by sel
  input  wire logic                                       alarm_wr,
  input  wire logic                                       periodic_interval_wr,
  input  wire logic                                       chan_sel,
  input  wire logic [atc_pkg::CNT_W-1:0]                  alarm_wdata,
  input  wire logic [atc_pkg::SEL_W-1:0]                  interval_wdata,
  // Tuner word
  input  wire logic                                       tune_wr,
  input  wire atc_pkg::atc_tune_t                         tune_wdata,
  // Shutdown return
  input  wire logic                                       shutdown_wake,
  // Read back
  output atc_pkg::atc_ctrl_t                              ctrl_rdata,
  output logic [atc_pkg::CNT_W-1:0]                       counter_value,
  output logic [atc_pkg::CNT_W-1:0]                       calendar_value,
  output logic [atc_pkg::FLAG_W-1:0]                      status_flags,
  output logic                                            sync_busy,
  output logic                                            source_clock_switching,
  output logic                                            src_clk_en,
  output logic [atc_pkg::FLAG_W-1:0]                      irq_mask,
  output logic [atc_pkg::EVT_W-1:0]                       wake_enable_rdata,
  output logic [atc_pkg::EVT_W-1:0]                       event_mask,
  output logic [atc_pkg::N_CH-1:0][atc_pkg::CNT_W-1:0]    alarm_rdata,
  output logic [atc_pkg::N_CH-1:0][atc_pkg::SEL_W-1:0]    interval_rdata,
  output atc_pkg::atc_tune_t                              tune_rdata,
  // Interrupts, events, wake
  output logic                                            irq_overflow,
  output logic                                            irq_periodic,
  output logic                                            irq_alarm,
  output logic                                            irq_clock_settled,
  output logic                                            irq_ready,
  output logic [atc_pkg::EVT_W-1:0]                       event_pulse,
  output logic                                            wake_req
);

  localparam logic [atc_pkg::SYNC_CNT_W-1:0] SYNC_LOAD = atc_pkg::SYNC_CNT_W'(SYNC_CYCLES);
  localparam logic [atc_pkg::SYNC_CNT_W-1:0] CLK_LOAD  =
    atc_pkg::SYNC_CNT_W'(CLK_SYNC_CYCLES);
  localparam logic [atc_pkg::SYNC_CNT_W-1:0] CNT_ONE   = 4'h1;

  atc_pkg::atc_state_t                st_ff;
  atc_pkg::atc_state_t                nxt_st;
  atc_pkg::atc_cal_t                  cal_next;
  logic                               busy;
  logic                               sync_take;
  logic [8:0]                         tune_q;
  logic [atc_pkg::TUNE_CNT_W-1:0]     tune_period;
  logic [1:0]                         step;
  logic                               cnt_tick;
  logic                               match_clear;
  logic [atc_pkg::CNT_W-1:0]          cv_inc;
  logic [atc_pkg::EVT_W-1:0]          evt;
  logic [atc_pkg::FLAG_W-1:0]         flag_set;
  logic [atc_pkg::FLAG_W-1:0]         flag_clr;

  // Calendar carry logic
  atc_cal_step u_cal_step (
    .cal_cur (atc_pkg::atc_cal_t'(st_ff.cv)),
    .cal_nxt (cal_next)
  );

  // Synchronisation busy and accepted synchronised write
  assign busy      = (st_ff.busy_cnt != '0);
  assign sync_take = !busy && (ctrl_wr || cv_wr || calendar_value_wr || status_clear_wr ||
                     wake_enable_wr || event_mask_set_wr || event_mask_clear_wr ||
                     alarm_wr || periodic_interval_wr || tune_wr); // [R22]

  // Tuner period roundup(256/value) * 2^exp
  assign tune_q      = (st_ff.tune.value == 8'h00) ? 9'h000 :
                       9'((atc_pkg::TUNE_SPAN + {1'b0, st_ff.tune.value} - 9'h001) /
                          {1'b0, st_ff.tune.value});
  assign tune_period = atc_pkg::TUNE_CNT_W'(tune_q) << st_ff.tune.tune_exponent;

  // Next state of the whole core
  always_comb begin
    nxt_st      = st_ff;
    step        = 2'd0;
    cnt_tick    = 1'b0;
    match_clear = 1'b0;
    cv_inc      = st_ff.cv;
    evt         = atc_pkg::EVT_RST;
    flag_set    = atc_pkg::FLAG_RST;
    flag_clr    = atc_pkg::FLAG_RST;

    // Prescaler with digital tuning
    if (st_ff.ctrl.enable && st_ff.src_clk_en && src_tick) begin
      step = 2'd1;
      if (st_ff.tune.value != 8'h00) begin
        if (!st_ff.tune.add) begin
          if (st_ff.tune_cnt >= tune_period) begin
            step            = 2'd0; // [R20]
            nxt_st.tune_cnt = '0;
          end else begin
            nxt_st.tune_cnt = st_ff.tune_cnt + 40'h00_0000_0001;
          end
        end else begin
          if (st_ff.tune_cnt >= tune_period - 40'h00_0000_0002) begin
            step            = 2'd2; // [R21]
            nxt_st.tune_cnt = '0;
          end else begin
            nxt_st.tune_cnt = st_ff.tune_cnt + 40'h00_0000_0001;
          end
        end
      end
    end
    nxt_st.prsc = st_ff.prsc + atc_pkg::PRSC_W'(step);

    // Counter tick on rising edge of the selected tap
    cnt_tick = !st_ff.prsc[st_ff.ctrl.psel] && nxt_st.prsc[st_ff.ctrl.psel]; // [R24]
    if (cnt_tick) begin
      if (st_ff.ctrl.cal) begin
        cv_inc = cal_next; // [R1]
      end else begin
        cv_inc = st_ff.cv + 32'h0000_0001; // [R23]
        if (st_ff.cv == atc_pkg::CNT_TOP) begin
          evt[atc_pkg::FL_OVF] = 1'b1; // [R8]
        end
      end
      for (int i = 0; i < atc_pkg::N_CH; i++) begin
        if (cv_inc == st_ff.alarm_compare[i]) begin
          evt[atc_pkg::FL_ALARM0 + i] = 1'b1; // [R13] [R6]
          if (st_ff.ctrl.clr_on_alarm[i]) begin
            match_clear = 1'b1;
          end
        end
      end
      if (match_clear) begin
        cv_inc               = atc_pkg::CNT_RST; // [R15]
        evt[atc_pkg::FL_OVF] = 1'b1; // [R8]
      end
      nxt_st.cv = cv_inc;
    end

    // Periodic edges per channel
    for (int i = 0; i < atc_pkg::N_CH; i++) begin
      if (st_ff.ctrl.enable && !st_ff.prsc[st_ff.interval_bit_select[i]] &&
          nxt_st.prsc[st_ff.interval_bit_select[i]]) begin
        evt[atc_pkg::FL_PER0 + i] = 1'b1; // [R12]
      end
    end

    // Flag sources, including busy and switching falls
    flag_set[atc_pkg::EVT_W-1:0] = evt;
    flag_set[atc_pkg::FL_READY]  = (st_ff.busy_cnt == CNT_ONE); // [R9]
    flag_set[atc_pkg::FL_CLKRDY] = (st_ff.clk_busy_cnt == CNT_ONE); // [R9]

    // Busy countdowns
    if (busy) begin
      nxt_st.busy_cnt = st_ff.busy_cnt - CNT_ONE;
    end
    if (st_ff.clk_busy_cnt != '0) begin
      nxt_st.clk_busy_cnt = st_ff.clk_busy_cnt - CNT_ONE;
    end

    // Synchronised writes, discarded while busy
    if (!busy) begin
      if (ctrl_wr) begin
        nxt_st.ctrl      = ctrl_wdata;
        nxt_st.ctrl.pclr = 1'b0;
        if (ctrl_wdata.pclr) begin
          nxt_st.prsc = '0;
        end
      end
      if (cv_wr || calendar_value_wr) begin
        nxt_st.cv = cv_wdata; // [R1]
      end
      if (status_clear_wr) begin
        flag_clr = status_clear_wdata;
      end
      if (wake_enable_wr) begin
        nxt_st.wake_enable = wake_enable_wdata;
      end
      if (alarm_wr) begin
        nxt_st.alarm_compare[chan_sel] = alarm_wdata;
      end
      if (periodic_interval_wr) begin
        nxt_st.interval_bit_select[chan_sel] = interval_wdata;
      end
      if (tune_wr) begin
        nxt_st.tune     = tune_wdata;
        nxt_st.tune_cnt = '0;
      end
      if (event_mask_set_wr) begin
        nxt_st.event_mask = nxt_st.event_mask | event_mask_wdata; // [R16]
      end
      if (event_mask_clear_wr) begin
        nxt_st.event_mask = nxt_st.event_mask & ~event_mask_wdata; // [R16]
      end
    end
    if (sync_take) begin
      nxt_st.busy_cnt = SYNC_LOAD; // [R22]
    end

    // Flags and wake: a set in the clearing cycle wins
    nxt_st.flags = (st_ff.flags & ~flag_clr) | flag_set; // [R11]
    nxt_st.wake  = (st_ff.wake & ~flag_clr[atc_pkg::EVT_W-1:0]) |
                   (evt & st_ff.wake_enable); // [R17] [R18]
    nxt_st.evt   = evt & st_ff.event_mask; // [R16]

    // Interrupt mask set and clear, reset by shutdown return
    if (shutdown_wake) begin
      nxt_st.irq_mask = atc_pkg::FLAG_RST; // [R19]
    end else begin
      if (irq_mask_set_wr) begin
        nxt_st.irq_mask = nxt_st.irq_mask | irq_mask_wdata; // [R10]
      end
      if (irq_mask_clear_wr) begin
        nxt_st.irq_mask = nxt_st.irq_mask & ~irq_mask_wdata; // [R10]
      end
    end

    // Source clock enable with switching delay
    if (clk_en_wr && st_ff.clk_busy_cnt == '0) begin
      nxt_st.src_clk_en   = clk_en_wdata;
      nxt_st.clk_busy_cnt = CLK_LOAD;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Read back, synchronised words except the event mask read zero while busy
  assign ctrl_rdata             = busy ? '0 : st_ff.ctrl; // [R22]
  assign counter_value          = busy ? '0 : st_ff.cv;
  assign calendar_value         = busy ? '0 : st_ff.cv;
  assign wake_enable_rdata      = busy ? '0 : st_ff.wake_enable;
  assign alarm_rdata            = busy ? '0 : st_ff.alarm_compare;
  assign interval_rdata         = busy ? '0 : st_ff.interval_bit_select;
  assign tune_rdata             = busy ? '0 : st_ff.tune;
  assign status_flags           = st_ff.flags;
  assign sync_busy              = busy;
  assign source_clock_switching = (st_ff.clk_busy_cnt != '0);
  assign src_clk_en             = st_ff.src_clk_en;
  assign irq_mask               = st_ff.irq_mask;
  assign event_mask             = st_ff.event_mask;
  assign event_pulse            = st_ff.evt;
  assign wake_req               = (st_ff.wake != '0);

  // Five interrupt lines
  assign irq_overflow      = st_ff.flags[atc_pkg::FL_OVF] &
                             st_ff.irq_mask[atc_pkg::FL_OVF]; // [R7]
  assign irq_alarm         = |(st_ff.flags[atc_pkg::FL_ALARM0 +: atc_pkg::N_CH] &
                               st_ff.irq_mask[atc_pkg::FL_ALARM0 +: atc_pkg::N_CH]);
  assign irq_periodic      = |(st_ff.flags[atc_pkg::FL_PER0 +: atc_pkg::N_CH] &
                               st_ff.irq_mask[atc_pkg::FL_PER0 +: atc_pkg::N_CH]);
  assign irq_clock_settled = st_ff.flags[atc_pkg::FL_CLKRDY] & st_ff.irq_mask[atc_pkg::FL_CLKRDY];
  assign irq_ready         = st_ff.flags[atc_pkg::FL_READY] & st_ff.irq_mask[atc_pkg::FL_READY];

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_wrap_overflow: assert property ( // [R23]
    cnt_tick && !st_ff.ctrl.cal && st_ff.cv == atc_pkg::CNT_TOP && !(sync_take)
    |=> st_ff.cv == atc_pkg::CNT_RST && st_ff.flags[atc_pkg::FL_OVF])
    else $error("counter wrap did not clear and flag overflow");

  chk_busy_window: assert property ( // [R22]
    sync_take |=> busy [*3] ##1 !busy && st_ff.flags[atc_pkg::FL_READY])
    else $error("busy window length or ready flag wrong");

  chk_busy_discard: assert property ( // [R22]
    busy && ctrl_wr |=> $stable(st_ff.ctrl) && ctrl_rdata == '0 || !busy)
    else $error("control write taken while busy");

  chk_irq_hold: assert property ( // [R11]
    irq_overflow && !shutdown_wake && !irq_mask_clear_wr
    && !(sync_take && status_clear_wr && status_clear_wdata[atc_pkg::FL_OVF])
    |=> irq_overflow)
    else $error("overflow interrupt dropped without a clear");

  chk_mask_set: assert property ( // [R10]
    irq_mask_set_wr && irq_mask_wdata[atc_pkg::FL_ALARM0] && !irq_mask_clear_wr
    && !shutdown_wake |=> irq_mask[atc_pkg::FL_ALARM0])
    else $error("mask set write did not set the bit");

  chk_shutdown_mask: assert property ( // [R19]
    shutdown_wake |=> irq_mask == '0 && $stable(st_ff.ctrl) || $past(sync_take))
    else $error("shutdown return left the mask set");

  chk_wake_req: assert property ( // [R17]
    evt[atc_pkg::FL_PER0] && st_ff.wake_enable[atc_pkg::FL_PER0]
    |=> wake_req ##1 (wake_req || $past(status_clear_wr && !busy)))
    else $error("wake request missing after enabled periodic edge");

  chk_clock_settled: assert property ( // [R9]
    clk_en_wr && !source_clock_switching
    |=> source_clock_switching [*3] ##1 st_ff.flags[atc_pkg::FL_CLKRDY])
    else $error("clock settled flag not set after switching");

  chk_cal_seconds: assert property ( // [R25]
    cnt_tick && st_ff.ctrl.cal && st_ff.cv[5:0] == atc_pkg::SEC_LAST && !sync_take
    && !match_clear |=> st_ff.cv[5:0] == 6'h00 && st_ff.cv[11:6] != $past(st_ff.cv[11:6]))
    else $error("calendar seconds did not carry");

  chk_alarm_clear: assert property ( // [R15]
    match_clear && !sync_take |=> st_ff.cv == atc_pkg::CNT_RST && st_ff.flags[atc_pkg::FL_OVF])
    else $error("clear-on-match did not reset the counter");

endmodule

// *** rtl/atc_pkg.sv ***
// Shared constants, field layouts and state record of the async timer.
package atc_pkg;

  // Widths
  localparam int CNT_W      = 32;
  localparam int PRSC_W     = 32;
  localparam int SEL_W      = 5;
  localparam int N_CH       = 2;
  localparam int FLAG_W     = 7;
  localparam int EVT_W      = 5;
  localparam int TUNE_VAL_W = 8;
  localparam int TUNE_EXP_W = 5;
  localparam int TUNE_CNT_W = 40;
  localparam int SYNC_CNT_W = 4;

  // Flag, mask, wake and event bit positions (events use the low five)
  localparam int FL_OVF    = 0;
  localparam int FL_ALARM0 = 1;
  localparam int FL_PER0   = 3;
  localparam int FL_READY  = 5;
  localparam int FL_CLKRDY = 6;

  // Synchronisation times in clk_sys cycles
  localparam int SYNC_CYCLES     = 3;
  localparam int CLK_SYNC_CYCLES = 3;

  // Reset and top values
  localparam logic [CNT_W-1:0]  CNT_RST  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_TOP  = 32'hFFFF_FFFF;
  localparam logic [FLAG_W-1:0] FLAG_RST = 7'h00;
  localparam logic [EVT_W-1:0]  EVT_RST  = 5'h00;

  // Tuner arithmetic
  localparam logic [8:0] TUNE_SPAN = 9'h100;

  // Calendar limits
  localparam logic [5:0] SEC_LAST   = 6'h3B;
  localparam logic [5:0] MIN_LAST   = 6'h3B;
  localparam logic [4:0] HOUR_LAST  = 5'h17;
  localparam logic [4:0] DAY_FIRST  = 5'h01;
  localparam logic [3:0] MON_FIRST  = 4'h1;
  localparam logic [3:0] MON_FEB    = 4'h2;
  localparam logic [3:0] MON_APR    = 4'h4;
  localparam logic [3:0] MON_JUN    = 4'h6;
  localparam logic [3:0] MON_SEP    = 4'h9;
  localparam logic [3:0] MON_NOV    = 4'hB;
  localparam logic [3:0] MON_LAST   = 4'hC;
  localparam logic [4:0] DAYS_28    = 5'h1C;
  localparam logic [4:0] DAYS_29    = 5'h1D;
  localparam logic [4:0] DAYS_30    = 5'h1E;
  localparam logic [4:0] DAYS_31    = 5'h1F;
  localparam logic [5:0] LEAP_MASK  = 6'h03;

  // Packed date and time, low bit is seconds bit 0
  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } atc_cal_t;

  // Control word
  typedef struct packed {
    logic [SEL_W-1:0] psel;
    logic [N_CH-1:0]  clr_on_alarm;
    logic             cal;
    logic             pclr;
    logic             enable;
  } atc_ctrl_t;

  // Digital tuner word
  typedef struct packed {
    logic                  add;
    logic [TUNE_EXP_W-1:0] tune_exponent;
    logic [TUNE_VAL_W-1:0] value;
  } atc_tune_t;

  // Whole state of the timer core
  typedef struct packed {
    atc_ctrl_t                    ctrl;
    logic [CNT_W-1:0]             cv;
    logic [PRSC_W-1:0]            prsc;
    logic [FLAG_W-1:0]            flags;
    logic [FLAG_W-1:0]            irq_mask;
    logic [EVT_W-1:0]             wake_enable;
    logic [EVT_W-1:0]             event_mask;
    logic [EVT_W-1:0]             wake;
    logic [EVT_W-1:0]             evt;
    logic [N_CH-1:0][CNT_W-1:0]   alarm_compare;
    logic [N_CH-1:0][SEL_W-1:0]   interval_bit_select;
    atc_tune_t                    tune;
    logic [TUNE_CNT_W-1:0]        tune_cnt;
    logic [SYNC_CNT_W-1:0]        busy_cnt;
    logic                         src_clk_en;
    logic [SYNC_CNT_W-1:0]        clk_busy_cnt;
  } atc_state_t;

endpackage

// *** rtl/atc_cal_step.sv ***
// One-second advance of the packed date and time value.
`timescale 1ns/1ns
module atc_cal_step (
  // Current and next date
  input  wire atc_pkg::atc_cal_t cal_cur,
  output atc_pkg::atc_cal_t      cal_nxt
);

  logic [4:0] month_len;

  // Month length, February long when year offset divisible by four
  always_comb begin
    unique case (cal_cur.month)
      atc_pkg::MON_FEB: begin
        month_len = ((cal_cur.year & atc_pkg::LEAP_MASK) == 6'h00) ?
                    atc_pkg::DAYS_29 : atc_pkg::DAYS_28; // [R5]
      end
      atc_pkg::MON_APR, atc_pkg::MON_JUN, atc_pkg::MON_SEP, atc_pkg::MON_NOV: begin
        month_len = atc_pkg::DAYS_30;
      end
      default: begin
        month_len = atc_pkg::DAYS_31;
      end
    endcase
  end

  // Carry chain from seconds up to year
  always_comb begin
    cal_nxt = cal_cur;
    if (cal_cur.second != atc_pkg::SEC_LAST) begin
      cal_nxt.second = cal_cur.second + 6'h01; // [R25]
    end else begin
      cal_nxt.second = 6'h00;
      if (cal_cur.minute != atc_pkg::MIN_LAST) begin
        cal_nxt.minute = cal_cur.minute + 6'h01;
      end else begin
        cal_nxt.minute = 6'h00;
        if (cal_cur.hour != atc_pkg::HOUR_LAST) begin
          cal_nxt.hour = cal_cur.hour + 5'h01; // [R2]
        end else begin
          cal_nxt.hour = 5'h00;
          if (cal_cur.day < month_len) begin
            cal_nxt.day = cal_cur.day + 5'h01;
          end else begin
            cal_nxt.day = atc_pkg::DAY_FIRST; // [R3]
            if (cal_cur.month < atc_pkg::MON_LAST) begin
              cal_nxt.month = cal_cur.month + 4'h1;
            end else begin
              cal_nxt.month = atc_pkg::MON_FIRST;
              cal_nxt.year  = cal_cur.year + 6'h01; // [R4]
            end
          end
        end
      end
    end
  end

endmodule

// *** verif/tb_atc_core.sv ***
// Self-checking bench for the async timer core.
`timescale 1ns/1ns
module tb_atc_core;
  logic               clk_sys = 1'b0;
  logic               reset_n = 1'b0;
  logic               src_tick = 1'b0;
  logic               chan_sel = 1'b0;
  logic [13:0]        stb = 14'h0000;
  logic [31:0]        d = 32'h0000_0000;
  logic [4:0]         ev_seen = 5'h00;
  logic [67:0]        q[$];
  logic [67:0]        n;
  logic [6:0]         r, c;
  logic [5:0]         y;
  int                 error_cnt = 0;
  int                 samples_checked = 0;
  int                 cyc = 0;
  atc_pkg::atc_ctrl_t ctrl_rdata;
  logic [31:0]        counter_value, calendar_value, ex;
  logic [1:0][31:0]   alarm_rdata;
  logic [1:0][4:0]    interval_rdata;
  logic [4:0]         wake_enable_rdata;
  logic               sync_busy, source_clock_switching, src_clk_en;
  atc_pkg::atc_tune_t tune_rdata;
  logic [6:0]         status_flags, irq_mask;
  logic [4:0]         event_mask, event_pulse;
  logic               irq_overflow, irq_periodic, irq_alarm, irq_clock_settled, irq_ready;
  logic               wake_req;

  always #5 clk_sys = ~clk_sys;

  // Strobes and data shared from one write word
  atc_core i_atc_core (
    .clk_sys, .reset_n, .src_tick, .chan_sel, .clk_en_wr(stb[0]), .clk_en_wdata(d[0]),
    .ctrl_wr(stb[1]), .ctrl_wdata(d[9:0]), .cv_wr(stb[2]), .calendar_value_wr(stb[3]), .cv_wdata(d),
    .status_clear_wr(stb[4]), .status_clear_wdata(d[6:0]), .irq_mask_set_wr(stb[5]),
    .irq_mask_clear_wr(stb[6]), .irq_mask_wdata(d[6:0]), .wake_enable_wr(stb[7]),
    .wake_enable_wdata(d[4:0]), .event_mask_set_wr(stb[8]), .event_mask_clear_wr(stb[9]),
    .event_mask_wdata(d[4:0]), .alarm_wr(stb[10]), .periodic_interval_wr(stb[11]),
    .alarm_wdata(d), .interval_wdata(d[4:0]), .tune_wr(stb[13]), .tune_wdata(d[13:0]),
    .shutdown_wake(stb[12]), .ctrl_rdata, .counter_value, .calendar_value, .status_flags,
    .sync_busy, .source_clock_switching, .src_clk_en, .irq_mask,
    .wake_enable_rdata, .event_mask, .alarm_rdata, .interval_rdata, .tune_rdata,
    .irq_overflow, .irq_periodic, .irq_alarm, .irq_clock_settled, .irq_ready,
    .event_pulse, .wake_req);

  // Observed value by selector
  function automatic logic [31:0] obs(input logic [3:0] s);
    case (s)
      4'h0: return 32'(status_flags);
      4'h1: return 32'(irq_mask);
      4'h2: return counter_value;
      4'h3: return 32'(ctrl_rdata);
      4'h4: return 32'({irq_overflow, irq_periodic, irq_alarm, irq_clock_settled, irq_ready});
      4'h5: return 32'(event_mask);
      4'h7: return 32'({src_clk_en, source_clock_switching, sync_busy});
      4'h8: return calendar_value;
      4'h9: return 32'(tune_rdata);
      4'hA: return alarm_rdata[0];
      4'hB: return 32'({interval_rdata, wake_enable_rdata});
      default: return 32'({wake_req, ev_seen});
    endcase
  endfunction

  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One write, then wait out the busy window
  task automatic wr(input logic [13:0] s, input logic [31:0] v);
    @(negedge clk_sys);
    stb = s;
    d = v;
    @(negedge clk_sys);
    stb = 14'h0000;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic chk(input logic [3:0] s, input logic [31:0] m, input logic [31:0] e);
    q.push_back({s, m, e});
  endtask

  // Tick the prescaler until the watched field reaches the expected value, at most 300 cycles
  task automatic run(input logic [3:0] s, input logic [31:0] m, input logic [31:0] x);
    src_tick = 1'b1;
    for (int i = 0; i < 300 && (obs(s) & m) != x; i++) @(negedge clk_sys);
    src_tick = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // Watcher takes the oldest note and compares
  initial forever begin
    wait (q.size() > 0);
    n = q.pop_front();
    samples_checked++;
    if ((obs(n[67:64]) & n[63:32]) !== n[31:0]) begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, obs(n[67:64]) & n[63:32], n[31:0]);
    end
  end

  // Event capture and hang guard
  always @(posedge clk_sys) begin
    ev_seen <= ev_seen | event_pulse;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    r = 7'($urandom(32'hFFED));
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(4'h4, 32'h1F, 32'h00);
    wr(14'h0001, 32'h1);
    chk(4'h0, 32'h7F, 32'h40);
    chk(4'h7, 32'h7, 32'h4);
    r = 7'($urandom());
    c = 7'($urandom());
    wr(14'h0020, 32'(r));
    wr(14'h0040, 32'(c));
    chk(4'h1, 32'h7F, 32'(r & ~c));
    wr(14'h0020, 32'h7F);
    chk(4'h4, 32'h1F, 32'h02);
    wr(14'h0010, 32'h40);
    chk(4'h0, 32'h7F, 32'h20);
    // Control and counter writes inside the busy window are dropped
    @(negedge clk_sys);
    stb = 14'h0002;
    d = 32'h1;
    @(negedge clk_sys);
    stb = 14'h0006;
    d = 32'h1234_5678;
    chk(4'h3, 32'h3FF, 32'h0);
    chk(4'h7, 32'h1, 32'h1);
    @(negedge clk_sys);
    stb = 14'h0000;
    repeat (3) @(negedge clk_sys);
    chk(4'h2, 32'hFFFF_FFFF, 32'h0);
    chk(4'h3, 32'h3FF, 32'h001);
    // Wrap from the top value
    wr(14'h0180, 32'h1F);
    chk(4'h5, 32'h1F, 32'h1F);
    wr(14'h0004, 32'hFFFF_FFFE);
    run(4'h0, 32'h01, 32'h01);
    chk(4'h6, 32'h21, 32'h21);
    chk(4'h4, 32'h10, 32'h10);
    chk(4'h2, 32'hFFFF_FFFF, 32'h0);
    wr(14'h0200, 32'h03);
    chk(4'h5, 32'h1F, 32'h1C);
    // Clear-on-match alarm plus both periodic channels
    chan_sel = 1'b1;
    wr(14'h0C00, 32'hFFFF_0002);
    chan_sel = 1'b0;
    wr(14'h0400, 32'h10);
    chk(4'hA, 32'hFFFF_FFFF, 32'h10);
    chk(4'hB, 32'h7FFF, 32'h81F);
    wr(14'h0004, 32'h0);
    wr(14'h0010, 32'h7F);
    chk(4'h6, 32'h20, 32'h0);
    wr(14'h0002, 32'h009);
    run(4'h0, 32'h02, 32'h02);
    chk(4'h0, 32'h1F, 32'h1B);
    chk(4'h4, 32'h1C, 32'h1C);
    // Leap and plain February ends at midnight
    wr(14'h0002, 32'h005);
    for (int i = 0; i < 2; i++) begin
      y = i ? 6'h01 : 6'h04;
      ex = i ? {6'h01, 4'h3, 5'h01, 17'h0} : {6'h04, 4'h2, 5'h1D, 17'h0};
      wr(14'h0008, {y, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B});
      run(4'h2, 32'h3F, 32'h0);
      chk(4'h2, 32'hFFFF_FFFF, ex);
      chk(4'h8, 32'hFFFF_FFFF, ex);
    end
    wr(14'h1000, 32'h0);
    chk(4'h1, 32'h7F, 32'h00);
    chk(4'h3, 32'h3FF, 32'h005);
    // Slow then fast tuning, counter on prescaler bit 1
    wr(14'h0002, 32'h023);
    chk(4'h3, 32'h3FF, 32'h021);
    wr(14'h0004, 32'h0);
    wr(14'h2000, 32'h0180);
    chk(4'h9, 32'h3FFF, 32'h0180);
    src_tick = 1'b1;
    repeat (20) @(negedge clk_sys);
    src_tick = 1'b0;
    chk(4'h2, 32'hFFFF_FFFF, 32'h4);
    wr(14'h2000, 32'h2180);
    src_tick = 1'b1;
    repeat (21) @(negedge clk_sys);
    src_tick = 1'b0;
    chk(4'h2, 32'hFFFF_FFFF, 32'hB);
    @(negedge clk_sys);
    final_report();
  end
endmodule
